// ==== cst_params.svh ====
`ifndef CST_PARAMS_SVH
`define CST_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define CST_IDX_CTRL      12'hF29
`define CST_IDX_RSV_A     12'hF2A
`define CST_IDX_RSV_B     12'hF2B
`define CST_IDX_CNT_HI    12'hF2C
`define CST_IDX_CNT_LO    12'hF2D

`define CST_CTRL_RESET    8'h00
`define CST_CNT_HI_RESET  4'h0
`define CST_CNT_LO_RESET  8'h01

// control field positions
`define CST_BIT_POL       7
`define CST_BIT_HI_ACT    6
`define CST_BIT_HI_INACT  5
`define CST_BIT_LO_ACT    4
`define CST_BIT_LO_INACT  3
`define CST_BIT_CH2       2
`define CST_BIT_CH1       1
`define CST_BIT_CH0       0

`define CST_ADDR_W        16
`define CST_CH_N          3
`define CST_CNT_W         12

`endif

// ==== cst_pkg.sv ====
`include "cst_params.svh"

package cst_pkg;

    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`CST_ADDR_W-1:0] paddr;
        logic [31:0]            pwdata;
        logic [3:0]             pstrb;
    } cst_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } cst_apb_rsp_t;

    typedef struct packed {
        logic [`CST_CH_N-1:0] high;
        logic [`CST_CH_N-1:0] low;
    } cst_pwm_out_t;

    typedef struct packed {
        logic                 hold_polarity;
        logic                 high_side_active_term_en;
        logic                 high_side_inactive_term_en;
        logic                 low_side_active_term_en;
        logic                 low_side_inactive_term_en;
        logic [`CST_CH_N-1:0] channel_term_en;
    } cst_ctrl_t;

    typedef enum logic {
        CST_ST_IDLE,
        CST_ST_ACCESS
    } cst_phase_t;

    typedef struct packed {
        cst_ctrl_t   ctrl_reg;
        cst_phase_t  phase_reg;
        logic [31:0] rdata_reg;
        logic        err_reg;
        logic        hold_reg;
    } cst_top_state_t;

    typedef struct packed {
        logic [`CST_CNT_W-1:0] count_reg;
    } cst_cnt_state_t;

endpackage

// ==== cst_counter.sv ====
`timescale 1ns/1ns
`include "cst_params.svh"

module cst_counter (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // software load
    input  wire logic                  load_hi,
    input  wire logic                  load_lo,
    input  wire logic [7:0]            load_data,
    // count
    output logic      [`CST_CNT_W-1:0] count
);
    import cst_pkg::*;

    cst_cnt_state_t st_reg;
    cst_cnt_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // a load replaces the increment for that cycle
        if (load_hi || load_lo) begin
            if (load_hi) begin
                st_next.count_reg[11:8] = load_data[3:0];
            end
            if (load_lo) begin
                st_next.count_reg[7:0] = load_data;
            end
        end else begin
            st_next.count_reg = st_reg.count_reg + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.count_reg <= {`CST_CNT_HI_RESET, `CST_CNT_LO_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.count_reg;

endmodule

// ==== cst_top.sv ====
// Function
// - eight-bit trigger control register, read/write, resets zero
// - polarity bit picks hold on true or false
// - bit 6 adds all-high-side-active term
// - bit 5 adds all-high-side-inactive term
// - channel bits 2..0 include channel outputs
// - two addresses after control are reserved
// - count high byte: low nibble count, reset zero
// - twelve-bit counter split over high/low bytes
`timescale 1ns/1ns
`include "cst_params.svh"

module cst_top (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // register bus
    input  wire cst_pkg::cst_apb_req_t apb_req,
    output cst_pkg::cst_apb_rsp_t      apb_rsp,
    // pwm output states from the pwm core, same clock
    input  wire cst_pkg::cst_pwm_out_t pwm_out,
    // to the sample/hold stage
    output logic                       hold
);
    import cst_pkg::*;

    cst_top_state_t st_reg;
    cst_top_state_t st_next;

    logic [`CST_CNT_W-1:0] count;
    logic [7:0]            ctrl_byte;
    logic [11:0]           index;
    logic                  aligned;
    logic                  hit_ctrl;
    logic                  hit_rsv;
    logic                  hit_hi;
    logic                  hit_lo;
    logic                  hit_any;
    logic                  setup;
    logic                  wr_strobe;
    logic                  load_hi;
    logic                  load_lo;

    // per-channel masked outputs; a disabled channel is forced neutral in each product
    logic [`CST_CH_N-1:0]  hi_act_m;
    logic [`CST_CH_N-1:0]  hi_inact_m;
    logic [`CST_CH_N-1:0]  lo_act_m;
    logic [`CST_CH_N-1:0]  lo_inact_m;
    logic                  any_ch;
    logic                  hi_act_prod;
    logic                  hi_inact_prod;
    logic                  lo_act_prod;
    logic                  lo_inact_prod;
    logic                  terms;
    logic                  hold_next;
    logic [31:0]           rd_word;

    assign ctrl_byte = st_reg.ctrl_reg;

    // address decode: index in paddr[13:2], upper bits and lane bits must be zero
    assign index    = apb_req.paddr[13:2];
    assign aligned  = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[15:14] == 2'h0);
    assign hit_ctrl = aligned && (index == `CST_IDX_CTRL);
    assign hit_rsv  = aligned && ((index == `CST_IDX_RSV_A) || (index == `CST_IDX_RSV_B));
    assign hit_hi   = aligned && (index == `CST_IDX_CNT_HI);
    assign hit_lo   = aligned && (index == `CST_IDX_CNT_LO);
    assign hit_any  = hit_ctrl || hit_rsv || hit_hi || hit_lo;

    assign setup     = apb_req.psel && !apb_req.penable;
    // writes land on the access edge; pready is always high in access
    assign wr_strobe = apb_req.psel && apb_req.penable && apb_req.pwrite
                       && apb_req.pstrb[0] && (st_reg.phase_reg == CST_ST_ACCESS);
    assign load_hi   = wr_strobe && hit_hi;
    assign load_lo   = wr_strobe && hit_lo;

    cst_counter u_cst_counter (
        .pclk      (pclk),
        .presetn   (presetn),
        .load_hi   (load_hi),
        .load_lo   (load_lo),
        .load_data (apb_req.pwdata[7:0]),
        .count     (count)
    );

    genvar ch;
    generate
        for (ch = 0; ch < `CST_CH_N; ch++) begin : g_ch
            assign hi_act_m[ch]   = !st_reg.ctrl_reg.channel_term_en[ch]
                                    || pwm_out.high[ch];
            assign hi_inact_m[ch] = !st_reg.ctrl_reg.channel_term_en[ch]
                                    || !pwm_out.high[ch];
            assign lo_act_m[ch]   = !st_reg.ctrl_reg.channel_term_en[ch]
                                    || pwm_out.low[ch];
            assign lo_inact_m[ch] = !st_reg.ctrl_reg.channel_term_en[ch]
                                    || !pwm_out.low[ch];
        end
    endgenerate

    // with no channel selected a product would be vacuously true; treat it as false
    assign any_ch = |st_reg.ctrl_reg.channel_term_en;

    assign hi_act_prod   = st_reg.ctrl_reg.high_side_active_term_en
                           && any_ch && (&hi_act_m);
    assign hi_inact_prod = st_reg.ctrl_reg.high_side_inactive_term_en
                           && any_ch && (&hi_inact_m);
    assign lo_act_prod   = st_reg.ctrl_reg.low_side_active_term_en
                           && any_ch && (&lo_act_m);
    assign lo_inact_prod = st_reg.ctrl_reg.low_side_inactive_term_en
                           && any_ch && (&lo_inact_m);

    assign terms     = hi_act_prod || hi_inact_prod || lo_act_prod || lo_inact_prod;
    assign hold_next = st_reg.ctrl_reg.hold_polarity ? !terms : terms;

    // read word of the addressed register; reserved and unmapped read zero
    always_comb begin
        rd_word = 32'h00000000;
        if (aligned) begin
            case (index)
                `CST_IDX_CTRL: begin
                    rd_word = {24'h000000, ctrl_byte};
                end
                `CST_IDX_CNT_HI: begin
                    // upper nibble of the byte is reserved and reads zero
                    rd_word = {28'h0000000, count[11:8]};
                end
                `CST_IDX_CNT_LO: begin
                    rd_word = {24'h000000, count[7:0]};
                end
                `CST_IDX_RSV_A,
                `CST_IDX_RSV_B: begin
                    rd_word = 32'h00000000;
                end
                default: begin
                    rd_word = 32'h00000000;
                end
            endcase
        end
    end

    always_comb begin
        st_next          = st_reg;
        st_next.hold_reg = hold_next;
        case (st_reg.phase_reg)
            CST_ST_IDLE: begin
                if (setup) begin
                    st_next.phase_reg = CST_ST_ACCESS;
                    st_next.err_reg   = !hit_any;
                    // read data captured in setup so prdata comes from a flop
                    st_next.rdata_reg = rd_word;
                end
            end
            CST_ST_ACCESS: begin
                st_next.phase_reg = CST_ST_IDLE;
                if (wr_strobe && hit_ctrl) begin
                    st_next.ctrl_reg = cst_ctrl_t'(apb_req.pwdata[7:0]);
                end
                // reserved slots accept writes and drop them
            end
            default: begin
                st_next.phase_reg = CST_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.ctrl_reg  <= cst_ctrl_t'(`CST_CTRL_RESET);
            st_reg.phase_reg <= CST_ST_IDLE;
            st_reg.rdata_reg <= 32'h00000000;
            st_reg.err_reg   <= 1'b0;
            st_reg.hold_reg  <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // pready high only in access; zero wait states
    assign apb_rsp.pready  = apb_req.psel && apb_req.penable
                             && (st_reg.phase_reg == CST_ST_ACCESS);
    assign apb_rsp.prdata  = st_reg.rdata_reg;
    assign apb_rsp.pslverr = apb_rsp.pready && st_reg.err_reg;
    assign hold            = st_reg.hold_reg;

endmodule

// ==== cst_top_properties.sv ====
`timescale 1ns/1ns
module cst_top_properties
    import cst_pkg::*;
(
    // clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // watched ports
    input wire cst_apb_req_t apb_req,
    input wire cst_apb_rsp_t apb_rsp,
    input wire cst_pwm_out_t pwm_out,
    input wire logic         hold
);
    logic [7:0] c;
    logic [2:0] ch, hm, lm;
    logic       acc, rd, t;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd = acc && !apb_req.pwrite;
    assign ch = c[2:0];
    assign hm = pwm_out.high & ch;
    assign lm = pwm_out.low & ch;
    assign t = ch != 0 && (c[6] && hm == ch || c[5] && hm == 0 || c[4] && lm == ch || c[3] && lm == 0);
    // shadow of the control byte, written as the block takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) c <= 8'h00;
        else if (acc && apb_req.pwrite && apb_req.pstrb[0] && apb_req.paddr == 16'h3CA4)
            c <= apb_req.pwdata[7:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    hold_eq_a: assert property (hold == $past(c[7] ^ t))
        else $error("hold differs from term equation");
    hi_act_a: assert property (c[6] && !c[7] && ch != 0 && hm == ch |=> hold)
        else $error("high active term missed");
    hi_inact_a: assert property (c[5] && c[7] && ch != 0 && hm == 0 |=> !hold)
        else $error("high inactive term missed");
    lo_act_a: assert property (c[4] && !c[7] && ch != 0 && lm == ch |=> hold)
        else $error("low active term missed");
    lo_inact_a: assert property (c[3] && ch != 0 && lm == 0 |=> hold == !$past(c[7]))
        else $error("low inactive term missed");
    ch_off_a: assert property (ch == 0 |=> hold == $past(c[7]))
        else $error("disabled channels still used");
    no_term_a: assert property (c[7:3] == 5'h00 |=> !hold)
        else $error("hold with no term enabled");
    ctrl_rd_a: assert property (rd && apb_req.paddr == 16'h3CA4
        |-> apb_rsp.pready && apb_rsp.prdata == {24'h0, c})
        else $error("control readback wrong");
    rsv_gap_a: assert property (acc && apb_req.paddr inside {16'h3CA8, 16'h3CAC}
        |-> apb_rsp.pready && !apb_rsp.pslverr && apb_rsp.prdata == 0)
        else $error("reserved access misbehaves");
    cnt_hi_a: assert property (rd && apb_req.paddr == 16'h3CB0 |-> apb_rsp.prdata[31:4] == 0)
        else $error("count high byte upper bits set");
    cover property (acc && apb_req.paddr == 16'h3CA8);
    cover property (c[7] && t);
    cover property (!c[7] && t && c[6]);
endmodule

// ==== cst_pwm_model.sv ====
`timescale 1ns/1ns
module cst_pwm_model
    import cst_pkg::*;
(
    // clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // bench control
    input wire logic         rnd_en,
    input wire cst_pwm_out_t fix,
    // pwm output states toward the block
    output cst_pwm_out_t     pwm_out
);
    integer seed = 32'hc939;
    // random mode stresses the hold path every cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) pwm_out <= '0;
        else pwm_out <= rnd_en ? cst_pwm_out_t'(6'($random(seed))) : fix;
    end
endmodule

// ==== cst_top_bench.sv ====
`timescale 1ns/1ns
`include "cst_params.svh"
module cst_top_bench;
    import cst_pkg::*;
    logic         pclk, presetn, rnd_en, e;
    cst_apb_req_t req;
    cst_apb_rsp_t rsp;
    cst_pwm_out_t fix, pwm;
    logic         hold;
    logic [31:0]  r;
    logic [7:0]   c;
    logic [5:0]   p;
    integer       seed = 32'hc939;
    int           n_errors = 0;
    int           samples_checked = 0;
    logic [7:0]   cv [8] = '{8'h47, 8'hA7, 8'h17, 8'h0B, 8'h41, 8'h42, 8'h80, 8'h78};
    logic [5:0]   pv [8] = '{6'h38, 6'h00, 6'h07, 6'h3C, 6'h08, 6'h08, 6'h3F, 6'h3F};
    logic [15:0]  bad [3] = '{16'h0100, 16'h3CA5, 16'h7CA4};
    logic [3:0]   strb = 4'h1;
    cst_top u_cst_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .pwm_out(pwm), .hold(hold));
    cst_pwm_model u_cst_pwm_model (.pclk(pclk), .presetn(presetn), .rnd_en(rnd_en),
        .fix(fix), .pwm_out(pwm));
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask
    // request stands until pready is seen at a rising edge; the answer is taken there
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d, strb};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            n_errors++;
            $display("unexpected pready: expected 1 seen %b", rsp.pready);
            complete_run();
        end
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask
    function automatic logic exp_hold(logic [7:0] k, logic [5:0] q);
        logic [2:0] h, l, m;
        m = k[2:0];
        h = q[5:3] & m;
        l = q[2:0] & m;
        return k[7] ^ (m != 0 && (k[6] && h == m || k[5] && h == 0 || k[4] && l == m
            || k[3] && l == 0));
    endfunction
    // counter steps once per edge unless loaded
    function automatic logic [11:0] count_at(input logic [11:0] base, input int k);
        return base + 12'(k);
    endfunction
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        presetn = 0;
        req = '0;
        fix = '0;
        rnd_en = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, 16'h3CA4, 0);
        chk("ctrl reset", 0, r);
        apb(0, 16'h3CB0, 0);
        chk("count high reset", 0, r);
        $display("test reset done");
        for (int i = 0; i < 28; i++) begin
            c = i < 8 ? cv[i] : 8'($random(seed));
            p = i < 8 ? pv[i] : 6'($random(seed));
            fix <= cst_pwm_out_t'(p);
            apb(1, 16'h3CA4, {24'($random(seed)), c});
            apb(0, 16'h3CA4, 0);
            chk("ctrl", {24'h0, c}, r);
            repeat (2) @(posedge pclk);
            chk("hold", 32'(exp_hold(c, p)), 32'(hold));
        end
        rnd_en <= 1;
        for (int i = 0; i < 6; i++) begin
            apb(1, 16'h3CA4, $random(seed));
            repeat (20) @(posedge pclk);
        end
        rnd_en <= 0;
        $display("test hold done");
        for (int i = 0; i < 2; i++) begin
            apb(1, 16'h3CA8 + 16'(4 * i), 32'hFF);
            apb(0, 16'h3CA8 + 16'(4 * i), 0);
            chk("reserved data", 0, r);
            chk("reserved error", 0, 32'(e));
        end
        foreach (bad[i]) begin
            apb(0, bad[i], 0);
            chk("unmapped error", 1, 32'(e));
            chk("unmapped data", 0, r);
        end
        // a write with its low lane strobe off leaves the control byte alone
        apb(1, 16'h3CA4, 32'h5A);
        strb = 4'h0;
        apb(1, 16'h3CA4, 32'hFF);
        strb = 4'h1;
        apb(0, 16'h3CA4, 0);
        chk("ctrl strobe off", 32'h5A, r);
        $display("test map done");
        // low byte first so no carry reaches the loaded nibble; FFA after both loads
        apb(1, 16'h3CB4, 32'hF8);
        apb(1, 16'h3CB0, 32'hFFFF_FFAF);
        apb(0, 16'h3CB0, 0);
        chk("count high load", 32'(count_at(12'hFFA, 1) >> 8), r);
        repeat (12) @(posedge pclk);
        apb(0, 16'h3CB0, 0);
        chk("count high wrap", 32'(count_at(12'hFFA, 16) >> 8), r);
        apb(0, 16'h3CB4, 0);
        chk("count low", 32'(count_at(12'hFFA, 19) & 12'h0FF), r);
        $display("test count done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 16'h3CA4, 0);
        chk("ctrl after reset", 0, r);
        apb(0, 16'h3CB0, 0);
        chk("count high after reset", 0, r);
        apb(0, 16'h3CB4, 0);
        chk("count low after reset", 32'(count_at({`CST_CNT_HI_RESET, `CST_CNT_LO_RESET}, 7)
            & 12'h0FF), r);
        chk("hold after reset", 0, 32'(hold));
        $display("test reset again done");
        complete_run();
    end
endmodule
bind cst_top cst_top_properties u_cst_top_properties (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .pwm_out(pwm_out), .hold(hold));
